// ==== sysclk_defines.vh ====
// Constants for the system clock start/stop controller: register offsets,
// bit positions, reset values and timing figures.
// Assumes the includer runs at the clock rate given by SYSCLK_SYS_MHZ.
`ifndef SYSCLK_DEFINES_VH
`define SYSCLK_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets (8-bit address space)
// ----------------------------------------------------------------------
`define SYSCLK_ADDR_MAIN_OSC_CTRL   8'h00
`define SYSCLK_ADDR_PROC_CLK_CTRL   8'h01
`define SYSCLK_ADDR_MAIN_MODE_CTRL  8'h02
`define SYSCLK_ADDR_STAB_STATUS     8'h03
`define SYSCLK_ADDR_STAB_SELECT     8'h04
`define SYSCLK_ADDR_CTRL_STATE      8'h05

// ----------------------------------------------------------------------
// Bit positions
// ----------------------------------------------------------------------
`define SYSCLK_BIT_MAIN_HALT        7
`define SYSCLK_BIT_SUB_HALT         6
`define SYSCLK_BIT_SUB_FLAG         5
`define SYSCLK_BIT_SUB_REQ          4
`define SYSCLK_BIT_MAIN_REQ         0
`define SYSCLK_BIT_MAIN_FLAG        1
`define SYSCLK_BIT_EXT_MODE         2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SYSCLK_RST_MAIN_OSC_CTRL    8'hC0
`define SYSCLK_RST_STAB_SELECT      3'h4
`define SYSCLK_ZERO8                8'h00

// ----------------------------------------------------------------------
// Stabilisation figures
// ----------------------------------------------------------------------
`define SYSCLK_STAB_STEPS           5
`define SYSCLK_STAB_LAST            3'h4
`define SYSCLK_STAB_CNT_W           17
`define SYSCLK_SYS_MHZ              200
`define SYSCLK_REG_STAB_NS          1000
`define SYSCLK_REG_STAB_CYC         ((`SYSCLK_REG_STAB_NS * `SYSCLK_SYS_MHZ + 999) / 1000)
`define SYSCLK_PWR_CNT_W            16
`define SYSCLK_STAB_UNIT_DEF        2048

// ----------------------------------------------------------------------
// Clock source codes on the select output
// ----------------------------------------------------------------------
`define SYSCLK_SRC_INT              2'h0
`define SYSCLK_SRC_MAIN             2'h1
`define SYSCLK_SRC_SUB              2'h2

`endif

// ==== sysclk_sync.v ====
// Two-flop synchroniser for a group of asynchronous level inputs.
// Assumes inputs are levels that stay put for several clk_sys cycles.
`timescale 1ns/1ps

module sysclk_sync #(
    parameter W = 1
) (
    input  wire         clk_sys,
    input  wire         rst,
    input  wire [W-1:0] asyncIn,
    output wire [W-1:0] syncOut
);

    reg [W-1:0] stage1_reg;
    reg [W-1:0] stage2_reg;

    // First stage feeds only the second; nothing else may look at it
    always @(posedge clk_sys) begin
        if (rst) begin
            stage1_reg <= {W{1'b0}};
            stage2_reg <= {W{1'b0}};
        end else begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign syncOut = stage2_reg;

endmodule // sysclk_sync

// ==== sysclk_stab_counter.v ====
// Oscillation stabilisation counter: counts clk_sys cycles while the main
// crystal runs and reports which wait thresholds have elapsed.
// Assumes the caller holds run low whenever the crystal is not oscillating.
`timescale 1ns/1ps
`include "sysclk_defines.vh"

module sysclk_stab_counter #(
    parameter STAB_UNIT = `SYSCLK_STAB_UNIT_DEF
) (
    input  wire                          clk_sys,
    input  wire                          rst,
    input  wire                          run,
    input  wire [2:0]                    waitSel,
    output wire [`SYSCLK_STAB_STEPS-1:0] stabStatus,
    output wire                          stabDone
);

    // Threshold index clamp: codes past the last step mean the longest wait
    function [2:0] clampSel;
        input [2:0] sel;
        begin
            clampSel = (sel > `SYSCLK_STAB_LAST) ? `SYSCLK_STAB_LAST : sel;
        end
    endfunction

    // Saturation point is the longest threshold, sized to the counter on purpose
    localparam [`SYSCLK_STAB_CNT_W-1:0] LIMIT_ALL = STAB_UNIT * 32;

    reg  [`SYSCLK_STAB_CNT_W-1:0] count_reg;
    wire [`SYSCLK_STAB_CNT_W-1:0] limitCnt;

    // Thresholds are the unit times 1, 4, 8, 16 and 32
    genvar i;
    generate
        for (i = 0; i < `SYSCLK_STAB_STEPS; i = i + 1) begin : gStep
            localparam integer SHIFT = (i == 0) ? 0 : i + 1;
            localparam [`SYSCLK_STAB_CNT_W-1:0] LIMIT = STAB_UNIT * (1 << SHIFT);
            assign stabStatus[i] = (count_reg >= LIMIT);
        end
    endgenerate

    assign limitCnt = LIMIT_ALL;

    // Saturating count; cleared whenever oscillation stops so a restart waits again
    always @(posedge clk_sys) begin
        if (rst) begin
            count_reg <= {`SYSCLK_STAB_CNT_W{1'b0}};
        end else if (!run) begin
            count_reg <= {`SYSCLK_STAB_CNT_W{1'b0}};
        end else if (count_reg < limitCnt) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    assign stabDone = stabStatus[clampSel(waitSel)];

endmodule // sysclk_stab_counter

// ==== sysclk_ctrl.v ====
// Clock generator control: oscillator enables, CPU clock source choice,
// STOP mode entry and release, and the register port for software.
// Assumes stopExec comes from the CPU on clk_sys; wake and sub-stable are pins.
//
// Functional notes
// R1: Internal high-speed oscillator runs from reset release without software.
// R2: CPU starts on internal clock after regulator stabilisation wait elapses.
// R3: Software enables main and sub crystals; both stay idle after reset.
// R4: Software switches to a crystal only after it oscillates stably.
// R5: Stabilisation counter status is readable while CPU runs on internal clock.
// R6: Running on main crystal, STOP release waits the selected stabilisation time.
// R7: External clock input imposes no stabilisation wait.
// R8: STOP instruction enters STOP, halting main crystal or gating external clock.
// R9: Software programs the wait select before STOP while on main crystal.
// R10: Software halts peripherals unusable in STOP before entering it.
// R11: Main halt bit set halts main crystal or external input without STOP.
// R12: Sub flag and main flag encode internal, high-speed or subsystem source.
// R13: Software sets main halt only when off high-speed clock, peripherals stopped.
// R14: Software leaves high-speed clock first if CPU runs on it.
// R15: Source flags change only once a requested switch has truly completed.
`timescale 1ns/1ps
`include "sysclk_defines.vh"

module sysclk_ctrl #(
    parameter STAB_UNIT = `SYSCLK_STAB_UNIT_DEF
) (
    input  wire       clk_sys,
    input  wire       rst,
    input  wire [7:0] regAddr,
    input  wire [7:0] regWrData,
    input  wire       regWrite,
    input  wire       regRead,
    output reg  [7:0] regRdData,
    input  wire       stopExec,
    input  wire       wakeReq,
    input  wire       subOscStable,
    output reg        intOscEn,
    output reg        mainOscEn,
    output reg        subOscEn,
    output reg        extClkInEn,
    output reg  [1:0] cpuClkSel,
    output reg        cpuRun,
    output reg        stopMode
);

    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    localparam [3:0] ST_PWR  = 4'h1;
    localparam [3:0] ST_RUN  = 4'h2;
    localparam [3:0] ST_STOP = 4'h4;
    localparam [3:0] ST_WAIT = 4'h8;

    localparam [`SYSCLK_PWR_CNT_W-1:0] PWR_CYC = `SYSCLK_REG_STAB_CYC;
    localparam [7:0]                   RST_OSC = `SYSCLK_RST_MAIN_OSC_CTRL;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    reg  [3:0]                    state_reg;
    reg  [3:0]                    state_next;
    reg  [`SYSCLK_PWR_CNT_W-1:0]  pwrCnt_reg;
    reg                           mainHalt_reg;
    reg                           subHalt_reg;
    reg                           subReq_reg;
    reg                           mainReq_reg;
    reg                           extMode_reg;
    reg  [2:0]                    waitSel_reg;
    reg                           subFlag_reg;
    reg                           subFlag_next;
    reg                           mainFlag_reg;
    reg                           mainFlag_next;
    reg  [7:0]                    rdMux;
    wire [1:0]                    pinSync;
    wire                          wakeSync;
    wire                          subStableSync;
    wire [`SYSCLK_STAB_STEPS-1:0] stabStatus;
    wire                          stabDone;
    wire                          onMain;
    wire                          mainReady;
    wire                          subReady;
    wire                          stopNow;

    // ------------------------------------------------------------------
    // Pin synchronisers and stabilisation counter
    // ------------------------------------------------------------------
    sysclk_sync #(
        .W (2)
    ) uSync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .asyncIn ({wakeReq, subOscStable}),
        .syncOut (pinSync)
    );

    assign wakeSync      = pinSync[1];
    assign subStableSync = pinSync[0];

    // Counter runs only while the crystal is enabled, so each restart begins a fresh count
    sysclk_stab_counter #(
        .STAB_UNIT (STAB_UNIT)
    ) uStab (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .run        (mainOscEn),
        .waitSel    (waitSel_reg),
        .stabStatus (stabStatus),
        .stabDone   (stabDone)
    );  // see R5

    // ------------------------------------------------------------------
    // Derived conditions
    // ------------------------------------------------------------------
    assign onMain    = mainFlag_reg & ~subFlag_reg;
    // Full count before a switch keeps the CPU off a crystal still settling
    assign mainReady = extClkInEn | (mainOscEn & stabStatus[`SYSCLK_STAB_STEPS-1]);  // see R4
    assign subReady  = subOscEn & subStableSync;
    assign stopNow   = (state_reg == ST_STOP);

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // Crystals held halted out of reset until software clears the halt bits
    always @(posedge clk_sys) begin
        if (rst) begin
            mainHalt_reg <= RST_OSC[`SYSCLK_BIT_MAIN_HALT];  // see R3
            subHalt_reg  <= RST_OSC[`SYSCLK_BIT_SUB_HALT];   // see R3
            subReq_reg   <= 1'b0;
            mainReq_reg  <= 1'b0;
            extMode_reg  <= 1'b0;
            waitSel_reg  <= `SYSCLK_RST_STAB_SELECT;
        end else if (regWrite) begin
            if (regAddr == `SYSCLK_ADDR_MAIN_OSC_CTRL) begin
                mainHalt_reg <= regWrData[`SYSCLK_BIT_MAIN_HALT];  // see R11
                subHalt_reg  <= regWrData[`SYSCLK_BIT_SUB_HALT];
            end else if (regAddr == `SYSCLK_ADDR_PROC_CLK_CTRL) begin
                subReq_reg <= regWrData[`SYSCLK_BIT_SUB_REQ];
            end else if (regAddr == `SYSCLK_ADDR_MAIN_MODE_CTRL) begin
                mainReq_reg <= regWrData[`SYSCLK_BIT_MAIN_REQ];
                extMode_reg <= regWrData[`SYSCLK_BIT_EXT_MODE];
            end else if (regAddr == `SYSCLK_ADDR_STAB_SELECT) begin
                waitSel_reg <= regWrData[2:0];  // see R9
            end
        end
    end

    // ------------------------------------------------------------------
    // Register reads: data stands one cycle after the strobe only
    // ------------------------------------------------------------------
    always @* begin
        rdMux = `SYSCLK_ZERO8;
        if (regAddr == `SYSCLK_ADDR_MAIN_OSC_CTRL) begin
            rdMux[`SYSCLK_BIT_MAIN_HALT] = mainHalt_reg;
            rdMux[`SYSCLK_BIT_SUB_HALT]  = subHalt_reg;
        end else if (regAddr == `SYSCLK_ADDR_PROC_CLK_CTRL) begin
            rdMux[`SYSCLK_BIT_SUB_FLAG] = subFlag_reg;  // see R12
            rdMux[`SYSCLK_BIT_SUB_REQ]  = subReq_reg;
        end else if (regAddr == `SYSCLK_ADDR_MAIN_MODE_CTRL) begin
            rdMux[`SYSCLK_BIT_MAIN_REQ]  = mainReq_reg;
            rdMux[`SYSCLK_BIT_MAIN_FLAG] = mainFlag_reg;  // see R12
            rdMux[`SYSCLK_BIT_EXT_MODE]  = extMode_reg;
        end else if (regAddr == `SYSCLK_ADDR_STAB_STATUS) begin
            rdMux[`SYSCLK_STAB_STEPS-1:0] = stabStatus;  // see R5
        end else if (regAddr == `SYSCLK_ADDR_STAB_SELECT) begin
            rdMux[2:0] = waitSel_reg;
        end else if (regAddr == `SYSCLK_ADDR_CTRL_STATE) begin
            rdMux[3:0] = state_reg;
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            regRdData <= `SYSCLK_ZERO8;
        end else if (regRead) begin
            regRdData <= rdMux;
        end else begin
            regRdData <= `SYSCLK_ZERO8;
        end
    end

    // ------------------------------------------------------------------
    // Power-up regulator wait
    // ------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            pwrCnt_reg <= {`SYSCLK_PWR_CNT_W{1'b0}};
        end else if (state_reg == ST_PWR && pwrCnt_reg < PWR_CYC) begin
            pwrCnt_reg <= pwrCnt_reg + 1'b1;  // see R2
        end
    end

    // ------------------------------------------------------------------
    // Run / STOP state machine
    // ------------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_PWR: begin
                if (pwrCnt_reg >= PWR_CYC) begin
                    state_next = ST_RUN;  // see R2
                end
            end
            ST_RUN: begin
                if (stopExec) begin
                    state_next = ST_STOP;  // see R8
                end
            end
            ST_STOP: begin
                if (wakeSync) begin
                    // Only a crystal that was really stopped needs settling time
                    if (onMain && !extMode_reg && !mainHalt_reg) begin
                        state_next = ST_WAIT;  // see R6
                    end else begin
                        state_next = ST_RUN;  // see R7
                    end
                end
            end
            ST_WAIT: begin
                if (stabDone) begin
                    state_next = ST_RUN;  // see R6
                end
            end
            default: begin
                state_next = ST_PWR;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= ST_PWR;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Clock source switching; flags move only when the target is ready
    // ------------------------------------------------------------------
    always @* begin
        subFlag_next  = subFlag_reg;
        mainFlag_next = mainFlag_reg;
        if (state_reg == ST_RUN) begin
            if (subReq_reg) begin
                if (!subFlag_reg && subReady) begin
                    subFlag_next = 1'b1;  // see R15
                end
            end else if (subFlag_reg) begin
                if (!mainReq_reg || mainReady) begin
                    subFlag_next  = 1'b0;  // see R15
                    mainFlag_next = mainReq_reg;
                end
            end
            if (!subReq_reg && !subFlag_reg) begin
                if (mainReq_reg && !mainFlag_reg && mainReady) begin
                    mainFlag_next = 1'b1;  // see R15
                end else if (!mainReq_reg) begin
                    mainFlag_next = 1'b0;
                end
            end
            if (subReq_reg && !subFlag_reg && subReady) begin
                mainFlag_next = mainReq_reg;
            end
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            subFlag_reg  <= 1'b0;
            mainFlag_reg <= 1'b0;
        end else begin
            subFlag_reg  <= subFlag_next;
            mainFlag_reg <= mainFlag_next;
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs: oscillator enables and CPU clock
    // ------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            intOscEn   <= 1'b0;
            mainOscEn  <= 1'b0;
            subOscEn   <= 1'b0;
            extClkInEn <= 1'b0;
            cpuClkSel  <= `SYSCLK_SRC_INT;
            cpuRun     <= 1'b0;
            stopMode   <= 1'b0;
        end else begin
            intOscEn   <= 1'b1;  // see R1
            // STOP or the halt bit stops the crystal or gates the external input
            mainOscEn  <= ~mainHalt_reg & ~extMode_reg & ~stopNow;  // see R8, see R11
            extClkInEn <= ~mainHalt_reg & extMode_reg & ~stopNow;   // see R8, see R11
            subOscEn   <= ~subHalt_reg;
            if (subFlag_next) begin
                cpuClkSel <= `SYSCLK_SRC_SUB;  // see R12
            end else if (mainFlag_next) begin
                cpuClkSel <= `SYSCLK_SRC_MAIN;
            end else begin
                cpuClkSel <= `SYSCLK_SRC_INT;
            end
            cpuRun     <= (state_next == ST_RUN);  // see R2, see R6
            stopMode   <= (state_next == ST_STOP) | (state_next == ST_WAIT);
        end
    end

endmodule // sysclk_ctrl

// ==== sysclk_ctrl_sva.sv ====
// Checker for the clock start/stop controller, bound to its top module.
// Assumes a single clk_sys domain and a synchronous active-high rst.
`timescale 1ns/1ps
`include "sysclk_defines.vh"

module sysclk_ctrl_sva #(
    parameter STAB_UNIT = `SYSCLK_STAB_UNIT_DEF
) (
    input wire       clk_sys,
    input wire       rst,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire       regWrite,
    input wire       regRead,
    input wire [7:0] regRdData,
    input wire       stopExec,
    input wire       wakeReq,
    input wire       subOscStable,
    input wire       intOscEn,
    input wire       mainOscEn,
    input wire       subOscEn,
    input wire       extClkInEn,
    input wire [1:0] cpuClkSel,
    input wire       cpuRun,
    input wire       stopMode
);
    // ------------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------------
    logic [7:0]  pwrCnt_reg;   // Edges since reset release, saturating
    logic [15:0] mainCnt_reg;  // Edges with the main crystal enabled

    // Saturate so a long run never wraps into a false pass
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pwrCnt_reg <= 8'h00;
        end else if (pwrCnt_reg != 8'hFF) begin
            pwrCnt_reg <= pwrCnt_reg + 8'h01;
        end
    end

    // Cleared whenever the crystal is off, as the real settle restarts
    always_ff @(posedge clk_sys) begin
        if (rst || !mainOscEn) begin
            mainCnt_reg <= 16'h0000;
        end else if (mainCnt_reg != 16'hFFFF) begin
            mainCnt_reg <= mainCnt_reg + 16'h0001;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_int_osc_on: assert property (!$past(rst) && !$past(rst, 2) |-> intOscEn)
        else $error("internal oscillator off after reset release");
    a_cpu_reg_wait: assert property (cpuRun |-> pwrCnt_reg >= 8'hC8)
        else $error("CPU started before regulator wait");
    a_stop_entry: assert property (stopExec && cpuRun |=>
        !cpuRun && stopMode ##1 !mainOscEn && !extClkInEn)
        else $error("STOP entry did not halt CPU and main clock");
    a_rd_idle: assert property (!$past(regRead) |-> regRdData == 8'h00)
        else $error("read data not zero outside read cycle");
    a_sub_flag: assert property (regRead && regAddr == 8'h01 |=>
        regRdData[5] == ($past(cpuClkSel) == 2'h2))
        else $error("sub clock flag disagrees with source");
    a_main_flag: assert property (regRead && regAddr == 8'h02 |=>
        regRdData[1] == ($past(cpuClkSel) == 2'h1) || $past(cpuClkSel) == 2'h2)
        else $error("main select flag disagrees with source");
    a_main_settle: assert property (cpuClkSel == 2'h1 && $past(cpuClkSel) != 2'h1 |->
        $past(extClkInEn) || mainCnt_reg >= 32 * STAB_UNIT - 1)
        else $error("switched to main clock before it settled");
    a_sub_settle: assert property (cpuClkSel == 2'h2 && $past(cpuClkSel) != 2'h2 |->
        subOscEn && $past(subOscStable, 2))
        else $error("switched to sub clock before it was stable");
    a_wake_wait: assert property ($rose(cpuRun) && cpuClkSel == 2'h1 && mainOscEn
        && !extClkInEn |-> mainCnt_reg >= STAB_UNIT)
        else $error("restart on main crystal without settle wait");
    a_halt_bit: assert property (regWrite && regAddr == 8'h00 && regWrData[7] |=>
        ##1 !mainOscEn && !extClkInEn && !stopMode)
        else $error("halt bit did not stop main clock alone");

    c_stop: cover property (stopExec && cpuRun);
    c_main: cover property ($rose(cpuClkSel == 2'h1));
    c_sub: cover property ($rose(cpuClkSel == 2'h2));
endmodule // sysclk_ctrl_sva

bind sysclk_ctrl sysclk_ctrl_sva #(.STAB_UNIT(STAB_UNIT)) u_sva (
    .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .stopExec(stopExec), .wakeReq(wakeReq), .subOscStable(subOscStable),
    .intOscEn(intOscEn), .mainOscEn(mainOscEn), .subOscEn(subOscEn),
    .extClkInEn(extClkInEn), .cpuClkSel(cpuClkSel), .cpuRun(cpuRun),
    .stopMode(stopMode));

// ==== tb.sv ====
// Self-checking bench for the clock start/stop controller.
// Assumes STAB_UNIT of 4, so the longest settle is 128 cycles.
`timescale 1ns/1ps

module tb;
    logic       clk_sys, rst, regWrite, regRead, stopExec, wakeReq, subOscStable;
    logic [7:0] regAddr, regWrData, regRdData;
    logic       intOscEn, mainOscEn, subOscEn, extClkInEn, cpuRun, stopMode;
    logic [1:0] cpuClkSel;
    int         n_mismatch, checks, cycles;

    sysclk_ctrl #(.STAB_UNIT(4)) dut (
        .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .stopExec(stopExec), .wakeReq(wakeReq), .subOscStable(subOscStable),
        .intOscEn(intOscEn), .mainOscEn(mainOscEn), .subOscEn(subOscEn),
        .extClkInEn(extClkInEn), .cpuClkSel(cpuClkSel), .cpuRun(cpuRun),
        .stopMode(stopMode));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe edge
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1 chk(regRdData, exp);
    endtask

    task automatic waitSel(input logic [1:0] v, output int n);
        n = 0;
        while (cpuClkSel !== v && n < 400) begin
            @(posedge clk_sys);
            #1 n++;
        end
    endtask

    task automatic waitRun(output int n);
        n = 0;
        while (cpuRun !== 1'b1 && n < 400) begin
            @(posedge clk_sys);
            #1 n++;
        end
    endtask

    // STOP then wake; n is cycles from wake pin to CPU restart
    task automatic stopWake(output int n);
        @(posedge clk_sys);
        stopExec <= 1'b1;
        @(posedge clk_sys);
        stopExec <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 chk({cpuRun, stopMode, mainOscEn, extClkInEn}, 4'h4);
        rdChk(8'h05, 8'h04);
        @(posedge clk_sys);
        wakeReq <= 1'b1;
        waitRun(n);
        @(posedge clk_sys);
        wakeReq <= 1'b0;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        int n;
        repeat (2) @(posedge clk_sys);
        #1 chk({intOscEn, mainOscEn, subOscEn, cpuRun}, 4'h8);
        waitRun(n);
        chk(n >= 195 && n <= 205, 1'b1);
        chk(cpuClkSel, 2'h0);
        rdChk(8'h00, 8'hC0);
        rdChk(8'h04, 8'h04);
        wr(8'h3F, 8'hFF);
        rdChk(8'h3F, 8'h00);
        rdChk(8'h03, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_main();
        int n;
        wr(8'h00, 8'h40);
        rdChk(8'h03, 8'h00);
        wr(8'h02, 8'h01);
        waitSel(2'h1, n);
        chk(n >= 118 && n <= 140, 1'b1);
        rdChk(8'h02, 8'h03);
        rdChk(8'h03, 8'h1F);
        wr(8'h04, 8'h02);
        stopWake(n);
        chk(n >= 34 && n <= 48, 1'b1);
        chk(cpuClkSel, 2'h1);
        $display("test main done");
    endtask

    // Halt bit stops the crystal while the CPU keeps running
    task automatic t_halt();
        int n;
        wr(8'h02, 8'h00);
        waitSel(2'h0, n);
        wr(8'h00, 8'hC0);
        repeat (2) @(posedge clk_sys);
        #1 chk({mainOscEn, stopMode, cpuRun}, 3'h1);
        rdChk(8'h05, 8'h02);
        // On the internal clock with the crystal halted, wake needs no settle wait
        stopWake(n);
        chk(n <= 8, 1'b1);
        $display("test halt done");
    endtask

    task automatic t_ext();
        int n;
        wr(8'h00, 8'h40);
        wr(8'h02, 8'h04);
        wr(8'h02, 8'h05);
        waitSel(2'h1, n);
        chk(n <= 8, 1'b1);
        chk(extClkInEn, 1'b1);
        stopWake(n);
        chk(n <= 8, 1'b1);
        wr(8'h02, 8'h04);
        wr(8'h00, 8'hC0);
        repeat (2) @(posedge clk_sys);
        #1 chk({extClkInEn, cpuRun}, 2'h1);
        $display("test ext done");
    endtask

    // Sub request waits for the stable pin before switching
    task automatic t_sub();
        int n;
        wr(8'h02, 8'h00);
        wr(8'h00, 8'h80);
        wr(8'h01, 8'h10);
        repeat (8) @(posedge clk_sys);
        #1 chk({subOscEn, cpuClkSel}, 3'h4);
        @(posedge clk_sys);
        subOscStable <= 1'b1;
        waitSel(2'h2, n);
        chk(n >= 3 && n <= 4, 1'b1);
        rdChk(8'h01, 8'h30);
        wr(8'h01, 8'h00);
        waitSel(2'h0, n);
        rdChk(8'h01, 8'h00);
        $display("test sub done");
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Cut a hang short well past the expected run length
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            results();
        end
    end

    initial begin
        {rst, regWrite, regRead, stopExec, wakeReq, subOscStable} = 6'h20;
        {regAddr, regWrData} = 16'h0000;
        {n_mismatch, checks, cycles} = '0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_main();
        t_halt();
        t_ext();
        t_sub();
        results();
    end
endmodule // tb
